// *** verilog/isas_consts.vh ***
// Purpose: constants for the isa slave sram access block
// Assumes: 10 MHz clk_sys, 64 KB local sram, 8-bit proms
// Notes: included by the sequencer and top design files, not by the synchroniser
//
// What this block does
// - master or slave chosen by strap only
// - slave access style from bit 13
// - 24-byte io window, 16 bases
// - boot prom 8 to 64K, on-chip compare in master mode
// - boot prom bytes paired into 16 bits
// - shared match starts sram access, width converted
// - indexed io reaches sram data and pointer
// - 16-bit data port access becomes two bytes
// - shared mode presents prom and sram 16-bit
// - prefetch next ascending sram word
// - valid prefetch served after one wait clock
// - invalid prefetch stretches cycle until fetched
// - local sram owned by this device
// - registers and address prom same both modes
// - netboot comes up active, else inactive
// - misc config two loaded from word 0x10
// - inactive device ignores all accesses
`ifndef ISAS_CONSTS_VH
`define ISAS_CONSTS_VH

`define ISAS_IO_BASE0 10'h200
`define ISAS_IO_SPAN 10'h018
`define ISAS_OFF_RDP 5'h10
`define ISAS_OFF_RAP 5'h12
`define ISAS_OFF_RST 5'h14
`define ISAS_OFF_IDP 5'h16

`define ISAS_IDX_WIN_A 7'h00
`define ISAS_IDX_WIN_B 7'h01
`define ISAS_IDX_BCR2 7'h02
`define ISAS_IDX_MISC2 7'h09
`define ISAS_BCR2_ARCH_BIT 13
`define ISAS_BCR2_RESET 16'h0000
`define ISAS_MISC2_RESET 16'h0000
`define ISAS_BOOT_RESET 16'h0000

`define ISAS_EE_W_BOOT 6'h08
`define ISAS_EE_W_BCR2 6'h0A
`define ISAS_EE_W_MISC2 6'h10

`define ISAS_TGT_SRAM 2'h0
`define ISAS_TGT_PROM 2'h1
`define ISAS_TGT_APROM 2'h2

`define ISAS_CLK_NS 100
`define ISAS_SRAM_ACC_NS 150
`define ISAS_PROM_ACC_NS 250
`define ISAS_SRAM_CYC ((`ISAS_SRAM_ACC_NS + `ISAS_CLK_NS - 1) / `ISAS_CLK_NS)
`define ISAS_PROM_CYC ((`ISAS_PROM_ACC_NS + `ISAS_CLK_NS - 1) / `ISAS_CLK_NS)

`endif

// *** verilog/isas_sync.v ***
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to clk_sys
// Notes: first stage feeds only the second
`timescale 1ns/100ps
module isas_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk_sys,
  input wire resetn,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule

// *** verilog/isas_mem_seq.v ***
// Purpose: byte sequencer for local sram and 8-bit proms
// Assumes: one byte per access, fixed access counts
// Notes: two-byte runs fill low byte first
`timescale 1ns/100ps
`include "isas_consts.vh"
module isas_mem_seq (
  input wire clk_sys,
  input wire resetn,
  input wire start,
  input wire wrEn,
  input wire twoBytes,
  input wire [1:0] target,
  input wire [15:0] addr,
  input wire [15:0] wdata,
  input wire [7:0] memData,
  output wire busy,
  output reg done,
  output reg [15:0] rdata,
  output reg [15:0] memAddr,
  output reg [7:0] memWdata,
  output wire memWdOe,
  output wire sramCeN,
  output wire promCeN,
  output wire apromCeN,
  output wire memOeN,
  output wire memWeN
);
  reg act_q;
  reg second_q;
  reg wr_q;
  reg two_q;
  reg [1:0] tgt_q;
  reg [3:0] cnt_q;
  reg [15:0] wd_q;

  localparam [31:0] SRAM_CYC_W = `ISAS_SRAM_CYC;
  localparam [31:0] PROM_CYC_W = `ISAS_PROM_CYC;

  function [3:0] cycFor;
    input [1:0] t;
    begin
      cycFor = (t == `ISAS_TGT_SRAM) ? SRAM_CYC_W[3:0] : PROM_CYC_W[3:0];
    end
  endfunction

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      act_q <= 1'b0;
      second_q <= 1'b0;
      wr_q <= 1'b0;
      two_q <= 1'b0;
      tgt_q <= `ISAS_TGT_SRAM;
      cnt_q <= 4'h0;
      wd_q <= 16'h0000;
      done <= 1'b0;
      rdata <= 16'h0000;
      memAddr <= 16'h0000;
      memWdata <= 8'h00;
    end else begin
      done <= 1'b0;
      if (!act_q && start) begin
        act_q <= 1'b1;
        second_q <= 1'b0;
        wr_q <= wrEn;
        two_q <= twoBytes;
        tgt_q <= target;
        cnt_q <= cycFor(target);
        wd_q <= wdata;
        memAddr <= addr;
        memWdata <= wdata[7:0];
      end else if (act_q) begin
        if (cnt_q > 4'h1) begin
          cnt_q <= cnt_q - 4'h1;
        end else begin
          if (second_q) begin
            rdata[15:8] <= memData;
          end else begin
            rdata[7:0] <= memData;
          end
          if (two_q && !second_q) begin
            second_q <= 1'b1;
            cnt_q <= cycFor(tgt_q);
            memAddr <= memAddr + 16'h0001;
            memWdata <= wd_q[15:8];
          end else begin
            act_q <= 1'b0;
            done <= 1'b1;
          end
        end
      end
    end
  end

  assign busy = act_q;
  assign memWdOe = act_q & wr_q;
  assign sramCeN = ~(act_q & (tgt_q == `ISAS_TGT_SRAM));
  assign promCeN = ~(act_q & (tgt_q == `ISAS_TGT_PROM));
  assign apromCeN = ~(act_q & (tgt_q == `ISAS_TGT_APROM));
  assign memOeN = ~(act_q & ~wr_q);
  // write strobe released in the last cycle so data holds past it
  assign memWeN = ~(act_q & wr_q & (cnt_q > 4'h1));
endmodule

// *** verilog/isas_slave_top.v ***
// Purpose: isa slave access path to local sram and proms
// Assumes: host strobes and data are asynchronous pins
// Notes: controller core registers lie outside this block
`timescale 1ns/100ps
`include "isas_consts.vh"
module isas_slave_top (
  input wire clk_sys,
  input wire resetn,
  input wire masterStrap,
  input wire netBootStrap,
  input wire cfgActivate,
  input wire [3:0] ioBaseSel,
  input wire eeLoadStb,
  input wire [5:0] eeWordAddr,
  input wire [15:0] eeWordData,
  input wire [19:0] isaAddr,
  input wire isaMemRdN,
  input wire isaMemWrN,
  input wire isaIoRdN,
  input wire isaIoWrN,
  input wire isaSbheN,
  input wire [15:0] isaDataIn,
  input wire bootRomMatchInN,
  input wire sharedSramMatchInN,
  output reg [15:0] isaDataOut,
  output wire isaDataOe,
  output wire ioChRdyOut,
  output wire ioChRdyOe,
  input wire [7:0] memData,
  output wire [15:0] memAddr,
  output wire [7:0] memWdata,
  output wire memWdOe,
  output wire sramCeN,
  output wire promCeN,
  output wire apromCeN,
  output wire memOeN,
  output wire memWeN,
  output wire deviceActive,
  output wire slaveMode,
  output wire indexedIoArchSelect
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_BUSY = 3'h1;
  localparam [2:0] S_PF = 3'h2;
  localparam [2:0] S_HOLD = 3'h3;

  localparam [2:0] K_NONE = 3'h0;
  localparam [2:0] K_SRAMRD = 3'h1;
  localparam [2:0] K_SRAMWR = 3'h2;
  localparam [2:0] K_PROM = 3'h3;
  localparam [2:0] K_APROM = 3'h4;
  localparam [2:0] K_REG = 3'h5;

  wire [19:0] sAddr;
  wire sMemRdN;
  wire sMemWrN;
  wire sIoRdN;
  wire sIoWrN;
  wire sSbheN;
  wire [15:0] sData;
  wire sBootN;
  wire sSramN;
  wire sMaster;
  wire sNetBoot;

  isas_sync #(.W(45), .INIT({20'h00000, 7'h7F, 16'h0000, 2'h3})) uHostSync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .din({isaAddr, isaMemRdN, isaMemWrN, isaIoRdN, isaIoWrN, isaSbheN,
          bootRomMatchInN, sharedSramMatchInN, isaDataIn, masterStrap, netBootStrap}),
    .dout({sAddr, sMemRdN, sMemWrN, sIoRdN, sIoWrN, sSbheN, sBootN, sSramN,
           sData, sMaster, sNetBoot})
  );

  reg [2:0] state_q;
  reg [1:0] strapCnt_q;
  reg strapDone_q;
  reg master_q;
  reg active_q;
  reg cmdPrev_q;
  reg [15:0] bcr2_q;
  reg [15:0] misc2_q;
  reg [15:0] bootCfg_q;
  reg [6:0] index_q;
  reg [15:0] ptr_q;
  reg hostReq_q;
  reg hostSel_q;
  reg [2:0] kind_q;
  reg rd_q;
  reg wide_q;
  reg pio_q;
  reg [15:0] addr_q;
  reg [15:0] wd_q;
  reg [4:0] off_q;
  reg [15:0] pfData_q;
  reg [15:0] pfAddr_q;
  reg pfValid_q;
  reg pfWant_q;
  reg engStart_q;
  reg engWr_q;
  reg engTwo_q;
  reg [1:0] engTgt_q;
  reg [15:0] engAddr_q;
  reg [15:0] engWd_q;

  wire engBusy;
  wire engDone;
  wire [15:0] engRdata;

  isas_mem_seq uSeq (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .start(engStart_q),
    .wrEn(engWr_q),
    .twoBytes(engTwo_q),
    .target(engTgt_q),
    .addr(engAddr_q),
    .wdata(engWd_q),
    .busy(engBusy),
    .done(engDone),
    .rdata(engRdata),
    .memData(memData),
    .memAddr(memAddr),
    .memWdata(memWdata),
    .memWdOe(memWdOe),
    .sramCeN(sramCeN),
    .promCeN(promCeN),
    .apromCeN(apromCeN),
    .memOeN(memOeN),
    .memWeN(memWeN)
  );

  // 8-bit odd bytes come back on the low lane
  function [15:0] laneOut;
    input [15:0] d;
    input a0;
    input wide;
    begin
      laneOut = wide ? d : {d[15:8], (a0 ? d[15:8] : d[7:0])};
    end
  endfunction

  // boot prom window: 8K times 2^size, base on 8K steps
  function bootCompare;
    input [6:0] a;
    input [6:0] base;
    input [1:0] size;
    reg [6:0] mask;
    begin
      mask = 7'h7F << size;
      bootCompare = ((a & mask) == (base & mask));
    end
  endfunction

  wire cmdAny = ~sMemRdN | ~sMemWrN | ~sIoRdN | ~sIoWrN;
  wire cycStart = cmdAny & ~cmdPrev_q;
  wire isMem = ~sMemRdN | ~sMemWrN;
  wire isRd = ~sMemRdN | ~sIoRdN;
  wire wide = ~sSbheN & ~sAddr[0];
  wire pioArch = bcr2_q[`ISAS_BCR2_ARCH_BIT];
  wire [9:0] ioBase = `ISAS_IO_BASE0 + {1'b0, ioBaseSel, 5'h00};
  wire [9:0] ioOff = sAddr[9:0] - ioBase;
  wire ioHit = ~isMem & (ioOff < `ISAS_IO_SPAN);
  wire bootHit = isMem & ~sMemRdN & (master_q ? bootCompare(sAddr[19:13], bootCfg_q[6:0],
                 bootCfg_q[9:8]) : ~sBootN);
  wire sramMemHit = isMem & ~master_q & ~pioArch & ~sSramN;
  wire idpSram = ioHit & (ioOff[4:0] == `ISAS_OFF_IDP) & (index_q == `ISAS_IDX_WIN_A)
                 & ~master_q & pioArch;

  reg [2:0] newKind;
  always @* begin
    newKind = K_NONE;
    if (bootHit) begin
      newKind = K_PROM;
    end else if (sramMemHit || idpSram) begin
      newKind = isRd ? K_SRAMRD : K_SRAMWR;
    end else if (ioHit && ioOff[4] == 1'b0) begin
      newKind = isRd ? K_APROM : K_NONE;
    end else if (ioHit) begin
      newKind = K_REG;
    end
  end

  reg [15:0] regRd;
  always @* begin
    regRd = 16'h0000;
    if (off_q == `ISAS_OFF_RAP) begin
      regRd = {9'h000, index_q};
    end else if (off_q == `ISAS_OFF_IDP) begin
      case (index_q)
        `ISAS_IDX_WIN_B: regRd = ptr_q;
        `ISAS_IDX_BCR2: regRd = bcr2_q;
        `ISAS_IDX_MISC2: regRd = misc2_q;
        default: regRd = 16'h0000;
      endcase
    end
  end

  wire [15:0] wordAddr = {addr_q[15:1], 1'b0};
  wire pfHit = pfValid_q & (pfAddr_q == wordAddr);
  wire [15:0] ptrStep = wide_q ? 16'h0002 : 16'h0001;

  // straps caught after they cross the synchroniser
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      strapCnt_q <= 2'h0;
      strapDone_q <= 1'b0;
      master_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      if (!strapDone_q) begin
        strapCnt_q <= strapCnt_q + 2'h1;
        if (strapCnt_q == 2'h3) begin
          strapDone_q <= 1'b1;
          master_q <= sMaster;
          active_q <= sNetBoot;
        end
      end else if (cfgActivate) begin
        active_q <= 1'b1;
      end
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      cmdPrev_q <= 1'b0;
      bcr2_q <= `ISAS_BCR2_RESET;
      misc2_q <= `ISAS_MISC2_RESET;
      bootCfg_q <= `ISAS_BOOT_RESET;
      index_q <= 7'h00;
      ptr_q <= 16'h0000;
      hostReq_q <= 1'b0;
      hostSel_q <= 1'b0;
      kind_q <= K_NONE;
      rd_q <= 1'b0;
      wide_q <= 1'b0;
      pio_q <= 1'b0;
      addr_q <= 16'h0000;
      wd_q <= 16'h0000;
      off_q <= 5'h00;
      pfData_q <= 16'h0000;
      pfAddr_q <= 16'h0000;
      pfValid_q <= 1'b0;
      pfWant_q <= 1'b0;
      engStart_q <= 1'b0;
      engWr_q <= 1'b0;
      engTwo_q <= 1'b0;
      engTgt_q <= `ISAS_TGT_SRAM;
      engAddr_q <= 16'h0000;
      engWd_q <= 16'h0000;
      isaDataOut <= 16'h0000;
    end else begin
      cmdPrev_q <= cmdAny;
      engStart_q <= 1'b0;
      if (eeLoadStb) begin
        if (eeWordAddr == `ISAS_EE_W_MISC2) begin
          misc2_q <= eeWordData;
        end
        if (eeWordAddr == `ISAS_EE_W_BCR2) begin
          bcr2_q <= eeWordData;
        end
        if (eeWordAddr == `ISAS_EE_W_BOOT) begin
          bootCfg_q <= eeWordData;
        end
      end
      if (cycStart && active_q && newKind != K_NONE) begin
        hostReq_q <= 1'b1;
        hostSel_q <= 1'b1;
        kind_q <= newKind;
        rd_q <= isRd;
        wide_q <= wide | (isMem & ~pioArch);
        pio_q <= idpSram;
        addr_q <= idpSram ? ptr_q : (bootHit ? sAddr[15:0] : (ioHit ?
                  {11'h000, ioOff[4:0]} : sAddr[15:0]));
        wd_q <= wide ? sData : {8'h00, sData[7:0]};
        off_q <= ioOff[4:0];
      end
      case (state_q)
        S_IDLE: begin
          if (hostReq_q) begin
            case (kind_q)
              K_SRAMRD: begin
                if (pfHit) begin
                  isaDataOut <= laneOut(pfData_q, addr_q[0], wide_q);
                  pfAddr_q <= wordAddr + 16'h0002;
                  pfValid_q <= 1'b0;
                  pfWant_q <= 1'b1;
                  hostReq_q <= 1'b0;
                  if (pio_q) begin
                    ptr_q <= ptr_q + ptrStep;
                  end
                  state_q <= S_HOLD;
                end else begin
                  engStart_q <= 1'b1;
                  engWr_q <= 1'b0;
                  engTwo_q <= 1'b1;
                  engTgt_q <= `ISAS_TGT_SRAM;
                  engAddr_q <= wordAddr;
                  state_q <= S_BUSY;
                end
              end
              K_SRAMWR: begin
                pfValid_q <= 1'b0;
                engStart_q <= 1'b1;
                engWr_q <= 1'b1;
                engTwo_q <= wide_q;
                engTgt_q <= `ISAS_TGT_SRAM;
                engAddr_q <= addr_q;
                engWd_q <= wd_q;
                state_q <= S_BUSY;
              end
              K_PROM: begin
                engStart_q <= 1'b1;
                engWr_q <= 1'b0;
                engTwo_q <= 1'b1;
                engTgt_q <= `ISAS_TGT_PROM;
                engAddr_q <= wordAddr;
                state_q <= S_BUSY;
              end
              K_APROM: begin
                engStart_q <= 1'b1;
                engWr_q <= 1'b0;
                engTwo_q <= 1'b1;
                engTgt_q <= `ISAS_TGT_APROM;
                engAddr_q <= wordAddr;
                state_q <= S_BUSY;
              end
              default: begin
                hostReq_q <= 1'b0;
                state_q <= S_HOLD;
                if (rd_q) begin
                  isaDataOut <= laneOut(regRd, 1'b0, wide_q);
                end else if (off_q == `ISAS_OFF_RAP) begin
                  index_q <= wd_q[6:0];
                end else if (off_q == `ISAS_OFF_IDP) begin
                  case (index_q)
                    `ISAS_IDX_WIN_B: begin
                      ptr_q <= wd_q;
                      pfValid_q <= 1'b0;
                    end
                    `ISAS_IDX_BCR2: bcr2_q <= wd_q;
                    `ISAS_IDX_MISC2: misc2_q <= wd_q;
                    default: index_q <= index_q;
                  endcase
                end
              end
            endcase
          end else if (pfWant_q && !master_q) begin
            engStart_q <= 1'b1;
            engWr_q <= 1'b0;
            engTwo_q <= 1'b1;
            engTgt_q <= `ISAS_TGT_SRAM;
            engAddr_q <= pfAddr_q;
            state_q <= S_PF;
          end
        end
        S_BUSY: begin
          if (engDone) begin
            hostReq_q <= 1'b0;
            isaDataOut <= laneOut(engRdata, addr_q[0], wide_q);
            if (kind_q == K_SRAMRD) begin
              pfAddr_q <= wordAddr + 16'h0002;
              pfWant_q <= 1'b1;
            end
            if (pio_q) begin
              ptr_q <= ptr_q + ptrStep;
            end
            state_q <= S_HOLD;
          end
        end
        S_PF: begin
          if (engDone) begin
            pfData_q <= engRdata;
            pfValid_q <= 1'b1;
            pfWant_q <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        S_HOLD: begin
          if (!cmdAny) begin
            hostSel_q <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  assign isaDataOe = hostSel_q & rd_q & cmdAny & (state_q == S_HOLD);
  assign ioChRdyOut = 1'b0;
  assign ioChRdyOe = hostReq_q;
  assign deviceActive = active_q;
  assign slaveMode = strapDone_q & ~master_q;
  assign indexedIoArchSelect = pioArch;
endmodule

// *** bench/isas_mem_model.sv ***
// Purpose: local sram and 8-bit prom model behind the slave block
// Assumes: byte wide parts, selects and strobes active low
// Notes: an unselected data bus shows a toggling pattern
`timescale 1ns/100ps
module isas_mem_model (
  input wire clk_sys,
  input wire [15:0] memAddr,
  input wire [7:0] memWdata,
  input wire sramCeN,
  input wire promCeN,
  input wire apromCeN,
  input wire memOeN,
  input wire memWeN,
  output logic [7:0] memData
);
  logic [7:0] sram [0:255];
  logic [7:0] junk = 8'hA5;
  always @(posedge clk_sys) begin
    junk <= ~junk;
    if (!sramCeN && !memWeN) begin
      sram[memAddr[7:0]] <= memWdata;
    end
  end
  always @* begin
    if (memOeN) memData = junk;
    else if (!sramCeN) memData = sram[memAddr[7:0]];
    else if (!promCeN) memData = memAddr[7:0] ^ 8'h5A;
    else if (!apromCeN) memData = ~memAddr[7:0];
    else memData = junk;
  end
endmodule

// *** bench/isas_slave_top_sva.sv ***
// Purpose: port checker for the isa slave access block
// Assumes: one clock domain, reset active low
// Notes: bound onto the top module below
`timescale 1ns/100ps
module isas_slave_top_sva (
  input wire clk_sys,
  input wire resetn,
  input wire isaMemRdN,
  input wire isaIoRdN,
  input wire isaDataOe,
  input wire ioChRdyOut,
  input wire ioChRdyOe,
  input wire [15:0] memAddr,
  input wire memWdOe,
  input wire sramCeN,
  input wire promCeN,
  input wire apromCeN,
  input wire memOeN,
  input wire memWeN,
  input wire deviceActive,
  input wire slaveMode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [5:0] waitCnt_q;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) waitCnt_q <= 6'h00;
    else if (ioChRdyOe) waitCnt_q <= waitCnt_q + 6'h01;
    else waitCnt_q <= 6'h00;
  end
  sequence sramOdd;
    ##[1:3] memAddr[0];
  endsequence
  sequence promOdd;
    !memAddr[0] ##[1:4] memAddr[0];
  endsequence
  inactive_quiet_a: assert property (!deviceActive |-> !isaDataOe && !ioChRdyOe)
    else $error("inactive device drives the host bus");
  wait_nodata_a: assert property (ioChRdyOe |-> !isaDataOe)
    else $error("data driven while wait is held");
  rdy_low_a: assert property (ioChRdyOe |-> !ioChRdyOut)
    else $error("wait line not pulled low");
  data_strobe_a: assert property (isaDataOe |-> !$past(isaMemRdN, 2) || !$past(isaIoRdN, 2)
    || !$past(isaMemRdN, 3) || !$past(isaIoRdN, 3))
    else $error("data driven without a read strobe");
  one_chip_a: assert property ($onehot0({~sramCeN, ~promCeN, ~apromCeN}))
    else $error("two memory selects at once");
  write_sram_a: assert property (!memWeN |-> memWdOe && !sramCeN && memOeN)
    else $error("write strobe outside an sram write");
  slave_hold_a: assert property (slaveMode |=> slaveMode)
    else $error("slave mode changed without reset");
  wait_bound_a: assert property (waitCnt_q < 6'h18)
    else $error("wait held too long");
  prom_pair_a: assert property ($fell(promCeN) |-> promOdd)
    else $error("prom word not fetched low byte then high byte");
  sram_pair_a: assert property ($fell(sramCeN) && !memOeN && !memAddr[0] |-> sramOdd)
    else $error("sram word not fetched in ascending byte order");
endmodule
bind isas_slave_top isas_slave_top_sva chk (.clk_sys(clk_sys), .resetn(resetn),
  .isaMemRdN(isaMemRdN), .isaIoRdN(isaIoRdN), .isaDataOe(isaDataOe), .ioChRdyOut(ioChRdyOut),
  .ioChRdyOe(ioChRdyOe), .memAddr(memAddr), .memWdOe(memWdOe), .sramCeN(sramCeN),
  .promCeN(promCeN), .apromCeN(apromCeN), .memOeN(memOeN), .memWeN(memWeN),
  .deviceActive(deviceActive), .slaveMode(slaveMode));

// *** bench/testbench.sv ***
// Purpose: self-checking bench for the isa slave access block
// Assumes: bench acts as isa host and outside decode logic
// Notes: each host cycle is held until the wait line lets go
`timescale 1ns/100ps
module testbench;
  localparam logic [19:0] IOB = 20'h00260;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic masterStrap = 1'b0;
  logic netBootStrap = 1'b0;
  logic cfgActivate = 1'b0;
  logic [3:0] ioBaseSel = 4'h3;
  logic eeLoadStb = 1'b0;
  logic [5:0] eeWordAddr = 6'h00;
  logic [15:0] eeWordData = 16'h0000;
  logic [19:0] isaAddr = 20'h00000;
  logic isaMemRdN = 1'b1, isaMemWrN = 1'b1, isaIoRdN = 1'b1, isaIoWrN = 1'b1;
  logic isaSbheN = 1'b0;
  logic [15:0] isaDataIn = 16'h0000;
  logic bootRomMatchInN = 1'b1;
  logic sharedSramMatchInN = 1'b1;
  logic [15:0] isaDataOut, memAddr, rd;
  logic [7:0] memData, memWdata;
  logic isaDataOe, ioChRdyOut, ioChRdyOe, memWdOe, sramCeN, promCeN, apromCeN, memOeN, memWeN;
  logic deviceActive, slaveMode, indexedIoArchSelect;
  int err_count = 0;
  int compares = 0;
  int waits;
  isas_slave_top DUT (.clk_sys(clk_sys), .resetn(resetn), .masterStrap(masterStrap),
    .netBootStrap(netBootStrap), .cfgActivate(cfgActivate), .ioBaseSel(ioBaseSel),
    .eeLoadStb(eeLoadStb), .eeWordAddr(eeWordAddr), .eeWordData(eeWordData), .isaAddr(isaAddr),
    .isaMemRdN(isaMemRdN), .isaMemWrN(isaMemWrN), .isaIoRdN(isaIoRdN), .isaIoWrN(isaIoWrN),
    .isaSbheN(isaSbheN), .isaDataIn(isaDataIn), .bootRomMatchInN(bootRomMatchInN),
    .sharedSramMatchInN(sharedSramMatchInN), .isaDataOut(isaDataOut), .isaDataOe(isaDataOe),
    .ioChRdyOut(ioChRdyOut), .ioChRdyOe(ioChRdyOe), .memData(memData), .memAddr(memAddr),
    .memWdata(memWdata), .memWdOe(memWdOe), .sramCeN(sramCeN), .promCeN(promCeN),
    .apromCeN(apromCeN), .memOeN(memOeN), .memWeN(memWeN), .deviceActive(deviceActive),
    .slaveMode(slaveMode), .indexedIoArchSelect(indexedIoArchSelect));
  isas_mem_model mem (.clk_sys(clk_sys), .memAddr(memAddr), .memWdata(memWdata),
    .sramCeN(sramCeN), .promCeN(promCeN), .apromCeN(apromCeN), .memOeN(memOeN),
    .memWeN(memWeN), .memData(memData));
  always #50 clk_sys = ~clk_sys;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask
  // one host cycle; waits stays 0 when the device does not answer
  task automatic host(input bit io, input bit wr, input logic [19:0] a, input logic [15:0] wd);
    isaAddr = a;
    isaDataIn = wd;
    tick(1);
    {isaIoWrN, isaIoRdN, isaMemWrN, isaMemRdN} = ~(4'h1 << {io, wr});
    waits = 0;
    for (int n = 0; n < 40; n++) begin
      tick(1);
      if (ioChRdyOe === 1'b1) waits++;
      else if (waits > 0 && (wr || isaDataOe === 1'b1)) break;
    end
    rd = isaDataOut;
    {isaIoWrN, isaIoRdN, isaMemWrN, isaMemRdN} = 4'hF;
    tick(14);
  endtask
  task automatic eeLoad(input logic [5:0] a, input logic [15:0] d);
    eeWordAddr = a;
    eeWordData = d;
    eeLoadStb = 1'b1;
    tick(1);
    eeLoadStb = 1'b0;
    tick(1);
  endtask
  task automatic doReset(input bit boot);
    netBootStrap = boot;
    resetn = 1'b0;
    tick(2);
    resetn = 1'b1;
    tick(8);
  endtask
  task automatic conclude;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #(20000 * 100);
    err_count++;
    conclude;
  end
  initial begin
    doReset(1'b0);
    check(16'(deviceActive), 16'h0000);
    host(1, 0, IOB + 20'h12, 16'h0000);
    check(16'(waits), 16'h0000);
    masterStrap = 1'b1;
    tick(4);
    check(16'(slaveMode), 16'h0001);
    masterStrap = 1'b0;
    cfgActivate = 1'b1;
    tick(1);
    cfgActivate = 1'b0;
    tick(1);
    check(16'(deviceActive), 16'h0001);
    eeLoad(6'h10, 16'h5A3C);
    eeLoad(6'h0A, 16'h0000);
    host(1, 1, IOB + 20'h12, 16'h0009);
    host(1, 0, IOB + 20'h16, 16'h0000);
    check(rd, 16'h5A3C);
    host(1, 0, IOB + 20'h04, 16'h0000);
    check(rd, 16'hFAFB);
    host(1, 0, 20'h00212, 16'h0000);
    check(16'(waits), 16'h0000);
    sharedSramMatchInN = 1'b0;
    host(0, 1, 20'h00020, 16'hBEEF);
    host(0, 1, 20'h00022, 16'hCAFE);
    check({mem.sram[8'h21], mem.sram[8'h20]}, 16'hBEEF);
    host(0, 0, 20'h00020, 16'h0000);
    check(rd, 16'hBEEF);
    check(16'(waits > 1), 16'h0001);
    host(0, 0, 20'h00022, 16'h0000);
    check(rd, 16'hCAFE);
    check(16'(waits), 16'h0001);
    host(0, 1, 20'h00024, 16'h1234);
    host(0, 0, 20'h00024, 16'h0000);
    check(rd, 16'h1234);
    sharedSramMatchInN = 1'b1;
    bootRomMatchInN = 1'b0;
    host(0, 0, 20'h00040, 16'h0000);
    check(rd, 16'h1B1A);
    bootRomMatchInN = 1'b1;
    eeLoad(6'h0A, 16'h2000);
    check(16'(indexedIoArchSelect), 16'h0001);
    sharedSramMatchInN = 1'b0;
    host(0, 0, 20'h00020, 16'h0000);
    check(16'(waits), 16'h0000);
    sharedSramMatchInN = 1'b1;
    host(1, 1, IOB + 20'h12, 16'h0001);
    host(1, 1, IOB + 20'h16, 16'h0080);
    host(1, 1, IOB + 20'h12, 16'h0000);
    host(1, 1, IOB + 20'h16, 16'hA55A);
    host(1, 1, IOB + 20'h16, 16'h3CC3);
    check({mem.sram[8'h81], mem.sram[8'h80]}, 16'hA55A);
    host(1, 1, IOB + 20'h12, 16'h0001);
    host(1, 1, IOB + 20'h16, 16'h0080);
    host(1, 1, IOB + 20'h12, 16'h0000);
    host(1, 0, IOB + 20'h16, 16'h0000);
    check(rd, 16'hA55A);
    host(1, 0, IOB + 20'h16, 16'h0000);
    check(rd, 16'h3CC3);
    check(16'(waits), 16'h0001);
    doReset(1'b1);
    check(16'(deviceActive), 16'h0001);
    masterStrap = 1'b1;
    doReset(1'b1);
    check(16'(slaveMode), 16'h0000);
    host(1, 0, IOB + 20'h04, 16'h0000);
    check(rd, 16'hFAFB);
    eeLoad(6'h08, 16'h0167);
    host(0, 0, 20'hCE010, 16'h0000);
    check(rd, 16'h4B4A);
    host(0, 0, 20'hD0010, 16'h0000);
    check(16'(waits), 16'h0000);
    conclude;
  end
endmodule
